//--- firing_time_consts.svh
`ifndef FIRING_TIME_CONSTS_SVH
`define FIRING_TIME_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define ADDR_CTRL        8'h00
`define ADDR_AZ          8'h04
`define ADDR_TADDR       8'h08
`define ADDR_TDATA       8'h0C
`define ADDR_STAT        8'h10
`define ADDR_T0_LO       8'h14
`define ADDR_T0_HI       8'h18
`define ADDR_COUNT       8'h1C

// ****************************************
// Field positions
// ****************************************
`define CTRL_DUAL        0
`define CTRL_HIRES       1
`define CTRL_STATE_LSB   2
`define CTRL_STATE_MSB   3
`define CTRL_PTP         4
`define AZ0_LSB          0
`define AZ0_MSB          1
`define AZ1_LSB          2
`define AZ1_MSB          3
`define STAT_AZ_ERR      0
`define STAT_SHUT        1
`define TADDR_MSB        10
`define TDATA_MSB        16

// ****************************************
// Reset values
// ****************************************
`define CTRL_RST         5'h00
`define AZ_RST           4'h0
`define TADDR_RST        11'h000
`define COUNT_RST        16'h0000

// ****************************************
// Timing, distance and table figures
// ****************************************
`define NS_PER_SEC       30'h3B9ACA00
`define NS_PER_US        10'h3E8
`define BLK_LEAD_NS      64'h0000000000000C4C
`define BLK_STEP_NS      64'h0000000000006C82
`define NEAR_LIMIT_MM    16'h0B22
`define COL_STD_BASE     4'h8
`define TBL_DEPTH        2048

`endif

//--- firing_time_pkg.sv
package firing_time_pkg;

	// ****************************************
	// Operational states
	// ****************************************
	typedef enum logic [1:0] {
		ST_HIGH_PERF,
		ST_STANDARD,
		ST_ENERGY_SAVE,
		ST_SHUTDOWN
	} op_state_t;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic [31:0] sec;
		logic [31:0] usec;
	} pkt_time_t;

	typedef struct packed {
		logic        blk;
		logic [6:0]  chan;
		logic [15:0] dist_mm;
	} point_t;

	typedef struct packed {
		logic        blk;
		logic [6:0]  chan;
		logic [63:0] time_ns;
	} fire_t;

	typedef struct packed {
		op_state_t       state;
		logic [1:0][1:0] az_flag;
	} tail_t;

	typedef struct packed {
		logic [63:0] blk1_ns;
		logic [63:0] blk0_ns;
	} blk_start_t;

endpackage : firing_time_pkg

//--- point_firing_time_calc.sv
// Functional notes
// - Each packet body carries exactly two data blocks.
// - Single return: one round per block, packet time is block two's trigger.
// - Dual return: one round fills both blocks, packet time is its trigger.
// - Packet time is date plus whole seconds plus microsecond stamp.
// - Microsecond part of packet time is a four-byte timestamp.
// - With a precision-time clock source no satellite-time packets are sent.
// - Single: block two at t0+3.148us, block one 27.778us or twice earlier.
// - Dual: both blocks start at t0+3.148us whatever the resolution.
// - Channel firing time is block start plus channel offset.
// - Tail reports one of four operational states.
// - Azimuth flag per block: 0..3 high performance, 0..1 otherwise.
// - Offset in ns by channel, state, flag, near/far; standard shares energy saving.
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`include "firing_time_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module point_firing_time_calc (
	input  wire logic                         i_clk,
	input  wire logic                         i_rst,
	input  wire logic [7:0]                   i_addr,
	input  wire logic [31:0]                  i_wdata,
	input  wire logic                         i_wr,
	input  wire logic                         i_rd,
	output logic      [31:0]                  o_rdata,
	input  wire logic                         i_pkt_valid,
	input  wire firing_time_pkg::pkt_time_t   i_pkt,
	input  wire logic                         i_pt_valid,
	input  wire firing_time_pkg::point_t      i_pt,
	output logic                              o_blk_valid,
	output firing_time_pkg::blk_start_t       o_blk_start,
	output logic                              o_fire_valid,
	output firing_time_pkg::fire_t            o_fire,
	output firing_time_pkg::tail_t            o_tail,
	output logic                              o_sat_pkt_en
);
	import firing_time_pkg::*;

	// ****************************************
	// Lookup helpers
	// ****************************************
	function automatic logic strobe_hit(input logic stb, input logic [7:0] a,
	                                    input logic [7:0] sel);
		strobe_hit = stb && (a == sel);
	endfunction : strobe_hit

	function automatic logic [1:0] eff_flag(input op_state_t st, input logic [1:0] fl);
		eff_flag = (st == ST_HIGH_PERF) ? fl : {1'b0, fl[0]};
	endfunction : eff_flag

	function automatic logic [3:0] col_of(input op_state_t st, input logic [1:0] fl,
	                                      input logic near);
		logic [1:0] f;
		f = eff_flag(st, fl);
		if (st == ST_HIGH_PERF) begin
			col_of = {1'b0, f, near};
		end else begin
			col_of = `COL_STD_BASE | {1'b0, 1'b0, f[0], near};
		end
	endfunction : col_of

	// ****************************************
	// Control registers
	// ****************************************
	logic                    dual_r;
	logic                    hires_r;
	op_state_t               state_r;
	logic                    ptp_r;
	logic [1:0][1:0]         az_r;
	logic [`TADDR_MSB:0]     taddr_r;
	logic [`TDATA_MSB:0]     tbl [`TBL_DEPTH];
	logic                    wr_ctrl;
	logic                    wr_az;
	logic                    wr_taddr;
	logic                    wr_tdata;
	logic                    wr_stat;
	logic [4:0]              ctrl_rst;

	assign ctrl_rst = `CTRL_RST;

	// Write strobe decode
	assign wr_ctrl  = strobe_hit(i_wr, i_addr, `ADDR_CTRL);
	assign wr_az    = strobe_hit(i_wr, i_addr, `ADDR_AZ);
	assign wr_taddr = strobe_hit(i_wr, i_addr, `ADDR_TADDR);
	assign wr_tdata = strobe_hit(i_wr, i_addr, `ADDR_TDATA);
	assign wr_stat  = strobe_hit(i_wr, i_addr, `ADDR_STAT);

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			dual_r  <= ctrl_rst[`CTRL_DUAL];
			hires_r <= ctrl_rst[`CTRL_HIRES];
			state_r <= op_state_t'(ctrl_rst[`CTRL_STATE_MSB:`CTRL_STATE_LSB]);
			ptp_r   <= ctrl_rst[`CTRL_PTP];
		end else if (wr_ctrl) begin
			dual_r  <= i_wdata[`CTRL_DUAL];
			hires_r <= i_wdata[`CTRL_HIRES];
			state_r <= op_state_t'(i_wdata[`CTRL_STATE_MSB:`CTRL_STATE_LSB]);
			ptp_r   <= i_wdata[`CTRL_PTP];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			az_r <= `AZ_RST;
		end else if (wr_az) begin
			az_r[0] <= i_wdata[`AZ0_MSB:`AZ0_LSB];
			az_r[1] <= i_wdata[`AZ1_MSB:`AZ1_LSB];
		end
	end

	// Table address steps after each data write
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			taddr_r <= `TADDR_RST;
		end else if (wr_taddr) begin
			taddr_r <= i_wdata[`TADDR_MSB:0];
		end else if (wr_tdata) begin
			taddr_r <= taddr_r + 11'h001;
		end
	end

	always_ff @(posedge i_clk) begin
		if (wr_tdata) begin
			tbl[taddr_r] <= i_wdata[`TDATA_MSB:0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_sat_pkt_en <= 1'b0;
		end else begin
			o_sat_pkt_en <= ~ptp_r;
		end
	end

	// ****************************************
	// Packet absolute time
	// ****************************************
	logic [63:0]     t0_r;
	logic            t0_vld_r;
	logic            pk_dual_r;
	logic            pk_hires_r;
	op_state_t       pk_state_r;
	logic [1:0][1:0] pk_az_r;
	logic [63:0]     sec_ns;
	logic [63:0]     usec_ns;

	assign sec_ns  = 64'(i_pkt.sec) * 64'(`NS_PER_SEC);
	assign usec_ns = 64'(i_pkt.usec) * 64'(`NS_PER_US);

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			t0_r     <= 64'h0000000000000000;
			t0_vld_r <= 1'b0;
		end else begin
			t0_vld_r <= i_pkt_valid;
			if (i_pkt_valid) begin
				t0_r <= sec_ns + usec_ns;
			end
		end
	end

	// Mode snapshot held for the whole packet
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			pk_dual_r  <= 1'b0;
			pk_hires_r <= 1'b0;
			pk_state_r <= ST_HIGH_PERF;
			pk_az_r    <= `AZ_RST;
		end else if (i_pkt_valid) begin
			pk_dual_r  <= dual_r;
			pk_hires_r <= hires_r;
			pk_state_r <= state_r;
			pk_az_r    <= az_r;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_tail <= '0;
		end else if (i_pkt_valid) begin
			o_tail.state      <= state_r;
			o_tail.az_flag[0] <= eff_flag(state_r, az_r[0]);
			o_tail.az_flag[1] <= eff_flag(state_r, az_r[1]);
		end
	end

	// ****************************************
	// Block start times
	// ****************************************
	logic [63:0] lead_ns;
	logic [63:0] back_ns;

	assign lead_ns = t0_r + `BLK_LEAD_NS;
	assign back_ns = pk_hires_r ? `BLK_STEP_NS : (`BLK_STEP_NS << 1);

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_blk_valid <= 1'b0;
			o_blk_start <= '0;
		end else begin
			o_blk_valid <= t0_vld_r;
			if (t0_vld_r) begin
				o_blk_start.blk1_ns <= lead_ns;
				o_blk_start.blk0_ns <= pk_dual_r ? lead_ns : (lead_ns - back_ns);
			end
		end
	end

	// ****************************************
	// Channel firing times
	// ****************************************
	logic                s1_vld_r;
	logic                s1_blk_r;
	logic [6:0]          s1_chan_r;
	logic [`TDATA_MSB:0] s1_ofs_r;
	logic                pt_near;
	logic                pt_shut;
	logic [3:0]          pt_col;
	logic [15:0]         fire_cnt_r;
	logic [15:0]         drop_cnt_r;

	assign pt_near = (i_pt.dist_mm <= `NEAR_LIMIT_MM);
	assign pt_shut = (pk_state_r == ST_SHUTDOWN);
	assign pt_col  = col_of(pk_state_r, pk_az_r[i_pt.blk], pt_near);

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			s1_vld_r  <= 1'b0;
			s1_blk_r  <= 1'b0;
			s1_chan_r <= 7'h00;
			s1_ofs_r  <= 17'h00000;
		end else begin
			s1_vld_r <= i_pt_valid && !pt_shut;
			if (i_pt_valid) begin
				s1_blk_r  <= i_pt.blk;
				s1_chan_r <= i_pt.chan;
				s1_ofs_r  <= tbl[{i_pt.chan, pt_col}];
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_fire_valid <= 1'b0;
			o_fire       <= '0;
		end else begin
			o_fire_valid <= s1_vld_r;
			if (s1_vld_r) begin
				o_fire.blk     <= s1_blk_r;
				o_fire.chan    <= s1_chan_r;
				o_fire.time_ns <= (s1_blk_r ? o_blk_start.blk1_ns : o_blk_start.blk0_ns)
				                  + 64'(s1_ofs_r);
			end
		end
	end

	// ****************************************
	// Status and counters
	// ****************************************
	logic az_err_r;
	logic shut_r;
	logic az_bad;

	// Flag above one outside high performance
	assign az_bad = i_pkt_valid && (state_r != ST_HIGH_PERF)
	                && (az_r[0][1] || az_r[1][1]);

	// Sticky error, set wins over clear
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			az_err_r <= 1'b0;
			shut_r   <= 1'b0;
		end else begin
			if (az_bad) begin
				az_err_r <= 1'b1;
			end else if (wr_stat && i_wdata[`STAT_AZ_ERR]) begin
				az_err_r <= 1'b0;
			end
			if (i_pt_valid && pt_shut) begin
				shut_r <= 1'b1;
			end else if (wr_stat && i_wdata[`STAT_SHUT]) begin
				shut_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			fire_cnt_r <= `COUNT_RST;
			drop_cnt_r <= `COUNT_RST;
		end else begin
			if (s1_vld_r) begin
				fire_cnt_r <= fire_cnt_r + 16'h0001;
			end
			if (i_pt_valid && pt_shut) begin
				drop_cnt_r <= drop_cnt_r + 16'h0001;
			end
		end
	end

	// ****************************************
	// Register read
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_rdata <= 32'h00000000;
		end else if (i_rd) begin
			unique case (i_addr)
				`ADDR_CTRL:  o_rdata <= {27'h0000000, ptp_r, state_r, hires_r, dual_r};
				`ADDR_AZ:    o_rdata <= {28'h0000000, az_r[1], az_r[0]};
				`ADDR_TADDR: o_rdata <= {21'h000000, taddr_r};
				`ADDR_TDATA: o_rdata <= {15'h0000, tbl[taddr_r]};
				`ADDR_STAT:  o_rdata <= {30'h00000000, shut_r, az_err_r};
				`ADDR_T0_LO: o_rdata <= t0_r[31:0];
				`ADDR_T0_HI: o_rdata <= t0_r[63:32];
				`ADDR_COUNT: o_rdata <= {drop_cnt_r, fire_cnt_r};
				default:     o_rdata <= 32'h00000000;
			endcase
		end else begin
			o_rdata <= 32'h00000000;
		end
	end

endmodule : point_firing_time_calc

`default_nettype wire

//--- firing_time_monitor.sv
`timescale 1ns/10ps
`default_nettype none
`include "firing_time_consts.svh"
// ****************************************
// Port checker
// ****************************************
module firing_time_monitor (
	input wire logic                       i_clk,
	input wire logic                       i_rst,
	input wire logic [7:0]                 i_addr,
	input wire logic [31:0]                i_wdata,
	input wire logic                       i_wr,
	input wire logic                       i_rd,
	input wire logic [31:0]                o_rdata,
	input wire logic                       i_pkt_valid,
	input wire firing_time_pkg::pkt_time_t i_pkt,
	input wire logic                       i_pt_valid,
	input wire firing_time_pkg::point_t    i_pt,
	input wire logic                       o_blk_valid,
	input wire firing_time_pkg::blk_start_t o_blk_start,
	input wire logic                       o_fire_valid,
	input wire firing_time_pkg::fire_t     o_fire,
	input wire firing_time_pkg::tail_t     o_tail,
	input wire logic                       o_sat_pkt_en
);
	import firing_time_pkg::*;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	logic [63:0] gap;
	logic [63:0] off;
	assign gap = o_blk_start.blk1_ns - o_blk_start.blk0_ns;
	assign off = o_fire.time_ns - (o_fire.blk ? o_blk_start.blk1_ns : o_blk_start.blk0_ns);
	chk_fire_cause: assert property (o_fire_valid |-> $past(i_pt_valid, 2))
		else $error("fire record without point");
	chk_blk_cause: assert property (o_blk_valid |-> $past(i_pkt_valid, 2))
		else $error("block starts without packet");
	chk_blk_timely: assert property (i_pkt_valid |-> ##2 o_blk_valid)
		else $error("block starts late");
	chk_blk_gap: assert property (o_blk_valid |-> gap == 64'h0 || gap == 64'h6C82
		|| gap == 64'hD904)
		else $error("block spacing wrong");
	chk_fire_offset: assert property (o_fire_valid |-> off < 64'h20000)
		else $error("fire offset out of range");
	chk_sat_ptp: assert property (i_wr && i_addr == `ADDR_CTRL
		|-> ##2 (o_sat_pkt_en == !$past(i_wdata[`CTRL_PTP], 2)))
		else $error("satellite packet enable wrong");
	chk_shut_quiet: assert property (o_fire_valid |-> o_tail.state != ST_SHUTDOWN)
		else $error("fire during shutdown");
	chk_flag_range: assert property (o_tail.state != ST_HIGH_PERF
		|-> !o_tail.az_flag[0][1] && !o_tail.az_flag[1][1])
		else $error("azimuth flag out of range");
	chk_blk_hold: assert property (!o_blk_valid |-> $stable(o_blk_start))
		else $error("block starts moved");
	cover property (o_fire_valid);
	cover property (o_blk_valid && gap == 64'h0);
	cover property (o_blk_valid && gap == 64'hD904);
endmodule : firing_time_monitor

bind point_firing_time_calc firing_time_monitor i_firing_time_monitor (.i_clk, .i_rst,
	.i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_pkt_valid, .i_pkt, .i_pt_valid, .i_pt,
	.o_blk_valid, .o_blk_start, .o_fire_valid, .o_fire, .o_tail, .o_sat_pkt_en);
`default_nettype wire

//--- fire_host.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Receiving host
// ****************************************
module fire_host (
	input wire logic                   i_clk,
	input wire logic                   i_rst,
	input wire logic                   i_fire_valid,
	input wire firing_time_pkg::fire_t i_fire
);
	import firing_time_pkg::*;
	int    fires_r;
	fire_t last_r;
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			fires_r <= 0;
		end else if (i_fire_valid) begin
			fires_r <= fires_r + 1;
			last_r  <= i_fire;
		end
	end
endmodule : fire_host
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "firing_time_consts.svh"
// ****************************************
// Testbench
// ****************************************
module tb_top;
	import firing_time_pkg::*;
	logic        i_clk, i_rst, i_wr, i_rd, i_pkt_valid, i_pt_valid;
	logic        o_blk_valid, o_fire_valid, o_sat_pkt_en;
	logic [7:0]  i_addr;
	logic [31:0] i_wdata, o_rdata;
	pkt_time_t   i_pkt;
	point_t      i_pt;
	blk_start_t  o_blk_start;
	fire_t       o_fire;
	tail_t       o_tail;
	logic [63:0] e0, e1;
	int          bad_count, checks_done;
	localparam logic [16:0] CH6 [12] = '{17'h0, 17'h0, 17'hADD, 17'hFBA, 17'h0, 17'h0,
		17'h97F, 17'h97F, 17'h775F, 17'h7C3C, 17'h7601, 17'h7601};
	point_firing_time_calc i_point_firing_time_calc (.i_clk, .i_rst, .i_addr, .i_wdata,
		.i_wr, .i_rd, .o_rdata, .i_pkt_valid, .i_pkt, .i_pt_valid, .i_pt, .o_blk_valid,
		.o_blk_start, .o_fire_valid, .o_fire, .o_tail, .o_sat_pkt_en);
	fire_host i_fire_host (.i_clk, .i_rst, .i_fire_valid(o_fire_valid), .i_fire(o_fire));
	initial begin
		i_clk = 0;
		forever #5 i_clk = ~i_clk;
	end
	task automatic report_and_stop();
		$display("Checks %0d, mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : report_and_stop
	task automatic fail(string m);
		$display("Error at %0t: %s", $time, m);
		bad_count++;
	endtask : fail
	task automatic cmp32(logic [31:0] g, logic [31:0] x, string m);
		checks_done++;
		if (g !== x) fail(m);
	endtask : cmp32
	task automatic cmp64(logic [63:0] g, logic [63:0] x, string m);
		checks_done++;
		if (g !== x) fail(m);
	endtask : cmp64
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge i_clk);
		i_addr <= a; i_wdata <= d; i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr
	task automatic rd(logic [7:0] a, logic [31:0] x, string m);
		@(posedge i_clk);
		i_addr <= a; i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 cmp32(o_rdata, x, m);
	endtask : rd
	task automatic send_pkt(logic [4:0] c, logic [3:0] az, logic [31:0] s, logic [31:0] u);
		logic [63:0] t0;
		int n;
		wr(`ADDR_AZ, {28'h0, az});
		wr(`ADDR_CTRL, {27'h0, c});
		t0 = 64'(s) * 64'h3B9ACA00 + 64'(u) * 64'h3E8;
		e1 = t0 + 64'hC4C;
		e0 = c[0] ? e1 : e1 - (c[1] ? 64'h6C82 : 64'hD904);
		@(posedge i_clk);
		i_pkt <= '{sec: s, usec: u}; i_pkt_valid <= 1'b1;
		@(posedge i_clk);
		i_pkt_valid <= 1'b0;
		n = 0;
		do begin
			@(posedge i_clk);
			#1 n++;
		end while (o_blk_valid !== 1'b1 && n < 8);
		if (o_blk_valid !== 1'b1) begin
			fail("no block starts");
			report_and_stop();
		end
		cmp64(o_blk_start.blk0_ns, e0, "block 0 start");
		cmp64(o_blk_start.blk1_ns, e1, "block 1 start");
		rd(`ADDR_T0_LO, t0[31:0], "t0 low");
		rd(`ADDR_T0_HI, t0[63:32], "t0 high");
	endtask : send_pkt
	task automatic send_pt(logic b, logic [15:0] d, logic [16:0] off, logic v);
		@(posedge i_clk);
		i_pt <= '{blk: b, chan: 7'h05, dist_mm: d}; i_pt_valid <= 1'b1;
		@(posedge i_clk);
		i_pt_valid <= 1'b0;
		@(posedge i_clk);
		#1 cmp32({31'h0, o_fire_valid}, {31'h0, v}, "fire valid");
		if (v) cmp64(o_fire.time_ns, (b ? e1 : e0) + 64'(off), "fire time");
		if (v) cmp32({24'h0, o_fire.blk, o_fire.chan}, {24'h0, b, 7'h05}, "fire chan");
	endtask : send_pt
	task automatic t_regs();
		rd(`ADDR_CTRL, 32'h0, "ctrl reset");
		rd(`ADDR_COUNT, 32'h0, "count reset");
		wr(`ADDR_TADDR, 32'h50);
		for (int i = 0; i < 12; i++) wr(`ADDR_TDATA, {15'h0, CH6[i]});
		wr(`ADDR_TADDR, 32'h53);
		rd(`ADDR_TDATA, 32'hFBA, "table readback");
		rd(8'h20, 32'h0, "unmapped read");
		$display("Test regs done");
	endtask : t_regs
	task automatic t_single();
		send_pkt(5'h02, 4'hD, 32'h10, 32'hF423F);
		cmp32({31'h0, o_sat_pkt_en}, 32'h1, "satellite enable");
		cmp32({30'h0, o_tail.az_flag[1]}, 32'h3, "tail flag high perf");
		send_pt(1'b0, 16'h0B22, 17'hFBA, 1'b1);
		send_pt(1'b1, 16'h0B23, 17'h97F, 1'b1);
		send_pkt(5'h04, 4'h1, 32'h20, 32'h0);
		send_pt(1'b0, 16'h0B22, 17'h7601, 1'b1);
		send_pt(1'b1, 16'hFFFF, 17'h775F, 1'b1);
		$display("Test single done");
	endtask : t_single
	task automatic t_dual();
		send_pkt(5'h0B, 4'h2, 32'h30, 32'h1);
		cmp32({30'h0, o_tail.state}, {30'h0, ST_ENERGY_SAVE}, "tail state");
		cmp32({30'h0, o_tail.az_flag[0]}, 32'h0, "tail flag");
		send_pt(1'b0, 16'h0001, 17'h7C3C, 1'b1);
		rd(`ADDR_STAT, 32'h1, "flag error set");
		wr(`ADDR_STAT, 32'h1);
		rd(`ADDR_STAT, 32'h0, "flag error clear");
		$display("Test dual done");
	endtask : t_dual
	task automatic t_shut();
		send_pkt(5'h1C, 4'h0, 32'h40, 32'h2);
		cmp32({31'h0, o_sat_pkt_en}, 32'h0, "satellite disable");
		send_pt(1'b1, 16'h0100, 17'h0, 1'b0);
		rd(`ADDR_STAT, 32'h2, "shutdown seen");
		rd(`ADDR_COUNT, 32'h00010005, "counts");
		cmp32(32'(i_fire_host.fires_r), 32'h5, "host records");
		cmp32({25'h0, i_fire_host.last_r.chan}, 32'h5, "host last chan");
		$display("Test shutdown done");
	endtask : t_shut
	initial begin
		#200000;
		fail("timeout");
		report_and_stop();
	end
	initial begin
		bad_count = 0; checks_done = 0;
		i_rst = 1'b1; i_wr = 1'b0; i_rd = 1'b0; i_addr = 8'h0; i_wdata = 32'h0;
		i_pkt_valid = 1'b0; i_pkt = '0; i_pt_valid = 1'b0; i_pt = '0;
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		t_regs();
		t_single();
		t_dual();
		t_shut();
		report_and_stop();
	end
endmodule : tb_top
`default_nettype wire
